// ===== src/octal_flash_read_features.sv
/*
 * read-side sequencer of an octal serial flash: octal single and double
 * rate reads, preamble training, wrap bursts and fast boot.
 * assumes link pins arrive asynchronously (sclk well below clk_sys_in/4),
 * an array port that answers each request once, a power of two buffer.
 */
`timescale 1ns/1ps

// Summary of operation
// - busy write cycle rejects single-rate octal read
// - busy write cycle rejects double-rate octal read
// - sixteen-bit preamble, switched by preamble enable
// - preamble fills dummy cycles after pre-drive
// - pattern select chooses one of two patterns
// - line three differs when pattern select clear
// - single-rate: twenty dummies full, fewer truncate
// - double-rate: twelve dummies carry full preamble
// - wrap byte: 1/2/3 give 16/32/64, 1x off
// - wrap unit sits inside current page
// - wrap off by default, kept until reset
// - bursts only in single-rate octal reads
// - fast boot reads automatically after any reset
// - boot data from start address, cs ends it
// - single-line boot delay is always thirteen
// - boot enable bit low enables fast boot
// - boot address bits 31..4, sixteen-byte aligned
module octal_flash_read_features
   import flash_read_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire link_in_t link_pins_in,
   output link_out_t link_pins_out,
   input wire cfg_t cfg_in,
   input wire logic program_busy_in,
   input wire logic [31:0] boot_configuration_in,
   output logic mem_req_valid_out,
   input wire logic mem_req_ready_in,
   output logic [31:0] mem_addr_out,
   input wire logic mem_rsp_valid_in,
   input wire logic [7:0] mem_rsp_data_in,
   output logic mem_rsp_ready_out,
   output logic cmd_reject_out,
   output logic wrap_enable_out,
   output logic boot_pending_out
);
   localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
   localparam logic [PTR_W:0] BUF_FULL = (PTR_W + 1)'(BUF_DEPTH);

   state_t state_q;
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic [7:0] io_s1_q, io_s2_q;
   logic [7:0] shift_q;
   logic [2:0] bit_q;
   logic [5:0] cnt_q;
   logic [31:0] addr_q;
   logic rd_dr_q, sr_read_q, boot_frame_q, boot_armed_q;
   logic wrap_en_q;
   logic [1:0] wrap_code_q;
   logic reject_q;
   logic outst_q;
   logic [7:0] io_q, oe_q;
   logic [7:0] buf_q [BUF_DEPTH];
   logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
   logic [PTR_W:0] buf_cnt_q;
   logic sclk_rise, sclk_fall, frame_start, dr_mode, octal;
   logic in_beat, out_beat, rx_phase, in_done;
   logic [7:0] in_byte, head;
   logic [5:0] dummy_beats, pre_start, pre_idx, boot_delay;
   logic pre_window, push, pop, req_fire, flush;

   // boot delay selection for octal protocols
   function automatic logic [5:0] boot_dly_of(input logic [1:0] code);
      case (code)
         2'h0: boot_dly_of = BOOT_DLY_00;
         2'h1: boot_dly_of = BOOT_DLY_01;
         2'h2: boot_dly_of = BOOT_DLY_10;
         default: boot_dly_of = BOOT_DLY_11;
      endcase
   endfunction

   // next fetch address, wrapping inside the burst unit if asked
   function automatic logic [31:0] next_addr(input logic [31:0] a,
                                             input logic wrap,
                                             input logic [1:0] code);
      logic [31:0] m;
      logic [31:0] inc;
      m = (32'h1 << (32'(code) + WRAP_SHIFT_BASE)) - 32'h1;
      inc = a + 32'h1;
      if (wrap) begin
         next_addr = (a & ~m) | (inc & m);
      end else begin
         next_addr = inc;
      end
   endfunction

   // preamble word on all eight lines for one bit position
   function automatic logic [7:0] preamble_of(input logic [5:0] idx,
                                              input logic sel);
      logic [3:0] b;
      b = 4'hf - idx[3:0];
      if (sel) begin
         preamble_of = {8{PREAMBLE_B[b]}};
      end else begin
         preamble_of = {8{PREAMBLE_A[b]}};
         preamble_of[LINE_THREE] = PREAMBLE_A_LINE3[b];
      end
   endfunction

   // two-flop synchronisers for the link pins
   always_ff @(posedge clk_sys_in) begin
      cs_s1_q <= link_pins_in.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sclk_s1_q <= link_pins_in.sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      io_s1_q <= link_pins_in.io;
      io_s2_q <= io_s1_q;
   end

   // link edges and beats
   assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
   assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
   assign frame_start = ~cs_s2_q & cs_s3_q;
   assign dr_mode = cfg_in.oct_dr_enable;
   assign octal = cfg_in.oct_dr_enable | cfg_in.oct_sr_enable;
   assign in_beat = sclk_rise | (dr_mode & sclk_fall);
   assign out_beat = sclk_fall | (dr_mode & sclk_rise);
   assign rx_phase = (state_q == ST_CMD) | (state_q == ST_WRAP)
                     | (state_q == ST_ADDR);
   assign in_done = in_beat & rx_phase & (octal | (bit_q == 3'h7));
   assign in_byte = octal ? io_s2_q : {shift_q[6:0], io_s2_q[0]};

   // dummy length and preamble window
   assign dummy_beats = dr_mode ? {cfg_in.dummy_cycles, 1'b0}
                                : {1'b0, cfg_in.dummy_cycles};
   assign pre_start = dr_mode ? PRE_DR_BEATS : PRE_SR_BEATS;
   assign pre_idx = cnt_q - pre_start;
   assign pre_window = (cnt_q >= pre_start) & (pre_idx < PREAMBLE_BITS);
   assign boot_delay = octal
      ? boot_dly_of(boot_configuration_in[BOOT_DLY_LSB +: 2])
      : BOOT_DLY_SPI;

   // serial bit counter and command shifter for single-line mode
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || frame_start) begin
         bit_q <= 3'h0;
      end else if (!octal && ((in_beat && rx_phase)
                   || (out_beat && state_q == ST_DATA))) begin
         bit_q <= bit_q + 3'h1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         shift_q <= 8'h00;
      end else if (in_beat && rx_phase && !octal) begin
         shift_q <= {shift_q[6:0], io_s2_q[0]};
      end
   end

   // frame sequencer
   always_ff @(posedge clk_sys_in) begin
      reject_q <= 1'b0;
      if (reset_in || cs_s2_q) begin
         state_q <= ST_IDLE;
         cnt_q <= 6'h00;
         if (reset_in) begin
            rd_dr_q <= 1'b0;
            sr_read_q <= 1'b0;
         end
      end else begin
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 6'h00;
               if (frame_start) begin
                  state_q <= boot_armed_q ? ST_BOOT : ST_CMD;
                  rd_dr_q <= boot_armed_q & dr_mode;
                  sr_read_q <= 1'b0;
               end
            end
            ST_CMD: begin
               if (in_done) begin
                  state_q <= ST_SKIP;
                  if (in_byte == OCT_SR_READ_CMD && !dr_mode && octal) begin
                     reject_q <= program_busy_in;
                     sr_read_q <= 1'b1;
                     if (!program_busy_in) state_q <= ST_ADDR;
                  end else if (in_byte == OCT_DR_READ_CMD && dr_mode) begin
                     reject_q <= program_busy_in;
                     rd_dr_q <= 1'b1;
                     if (!program_busy_in) state_q <= ST_ADDR;
                  end else if (in_byte == WRAP_SET_CMD) begin
                     state_q <= ST_WRAP;
                  end
               end
            end
            ST_WRAP: begin
               if (in_done) state_q <= ST_SKIP;
            end
            ST_ADDR: begin
               if (in_done) begin
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q == ADDR_LAST_BEAT) begin
                     state_q <= ST_DUMMY;
                     cnt_q <= 6'h00;
                  end
               end
            end
            ST_DUMMY: begin
               if (cnt_q >= dummy_beats) begin
                  state_q <= ST_DATA;
               end else if (in_beat) begin
                  cnt_q <= cnt_q + 6'h01;
               end
            end
            ST_BOOT: begin
               if (cnt_q >= boot_delay) begin
                  state_q <= ST_DATA;
               end else if (sclk_rise) begin
                  cnt_q <= cnt_q + 6'h01;
               end
            end
            ST_DATA: state_q <= ST_DATA;
            ST_SKIP: state_q <= ST_SKIP;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // boot arming: caught at reset or reset command, dropped after boot
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         boot_armed_q <= ~boot_configuration_in[BOOT_EN_N_BIT];
         boot_frame_q <= 1'b0;
      end else if (state_q == ST_CMD && in_done
                   && in_byte == SOFT_RESET_CMD) begin
         boot_armed_q <= ~boot_configuration_in[BOOT_EN_N_BIT];
      end else if (state_q == ST_IDLE && frame_start && boot_armed_q) begin
         boot_frame_q <= 1'b1;
      end else if (boot_frame_q && cs_s2_q) begin
         boot_armed_q <= 1'b0;
         boot_frame_q <= 1'b0;
      end
   end

   // wrap setting, cleared by any reset
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         wrap_en_q <= 1'b0;
         wrap_code_q <= WRAP_CODE_16;
      end else if (state_q == ST_CMD && in_done
                   && in_byte == SOFT_RESET_CMD) begin
         wrap_en_q <= 1'b0;
      end else if (state_q == ST_WRAP && in_done) begin
         if (in_byte[7:4] == WRAP_OFF_NIBBLE) begin
            wrap_en_q <= 1'b0;
         end else if (in_byte[7:4] == WRAP_SET_NIBBLE
                      && in_byte[3:0] != 4'h0
                      && in_byte[3:0] <= {2'h0, WRAP_CODE_64}) begin
            wrap_en_q <= 1'b1;
            wrap_code_q <= in_byte[1:0];
         end
      end
   end

   // fetch address: start address, then stepped per request
   assign req_fire = mem_req_valid_out & mem_req_ready_in;
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         addr_q <= 32'h0;
      end else if (state_q == ST_IDLE && frame_start && boot_armed_q) begin
         addr_q <= {boot_configuration_in[31:BOOT_ADDR_LSB], 4'h0};
      end else if (state_q == ST_ADDR && in_done) begin
         addr_q <= {addr_q[23:0], in_byte};
      end else if (req_fire) begin
         addr_q <= next_addr(addr_q, wrap_en_q & sr_read_q, wrap_code_q);
      end
   end

   // array request port, one request in flight
   assign mem_req_valid_out = ((state_q == ST_DUMMY) | (state_q == ST_BOOT)
                              | (state_q == ST_DATA)) & ~outst_q
                              & (buf_cnt_q < BUF_FULL);
   assign mem_addr_out = addr_q;
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         outst_q <= 1'b0;
      end else if (req_fire) begin
         outst_q <= 1'b1;
      end else if (push) begin
         outst_q <= 1'b0;
      end
   end

   // two-entry data buffer between array and link
   assign flush = (state_q == ST_IDLE);
   assign mem_rsp_ready_out = (buf_cnt_q < BUF_FULL);
   assign push = mem_rsp_valid_in & mem_rsp_ready_out;
   assign head = buf_q[rd_ptr_q];
   assign pop = out_beat & (state_q == ST_DATA) & (buf_cnt_q != '0)
                & (octal | (bit_q == 3'h7));
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         buf_cnt_q <= '0;
      end else begin
         if (push) begin
            buf_q[wr_ptr_q] <= mem_rsp_data_in;
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
         buf_cnt_q <= buf_cnt_q + (push ? 1'b1 : 1'b0)
                      - (pop ? 1'b1 : 1'b0);
      end
   end

   // pin drivers: preamble in dummy, data in data phase
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || cs_s2_q) begin
         io_q <= 8'h00;
         oe_q <= 8'h00;
      end else if (state_q == ST_DATA) begin
         if (out_beat && buf_cnt_q != '0) begin
            if (octal) begin
               io_q <= head;
               oe_q <= 8'hff;
            end else begin
               io_q <= {6'h00, head[3'h7 - bit_q], 1'b0};
               oe_q <= 8'h02;
            end
         end
      end else if (state_q == ST_DUMMY && cfg_in.preamble_enable
                   && octal) begin
         if (out_beat) begin
            oe_q <= 8'hff;
            io_q <= pre_window
                    ? preamble_of(pre_idx, cfg_in.pattern_select)
                    : 8'h00;
         end
      end else begin
         oe_q <= 8'h00;
      end
   end

   assign link_pins_out.io = io_q;
   assign link_pins_out.oe = oe_q;
   assign cmd_reject_out = reject_q;
   assign wrap_enable_out = wrap_en_q;
   assign boot_pending_out = boot_armed_q;

   // checks
   AST_WRAP_DEFAULT: assert property (@(posedge clk_sys_in)
      $past(reset_in) |-> !wrap_en_q)
      else $error("wrap not off after reset");
   AST_REJECT_SR: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_CMD && in_done && in_byte == OCT_SR_READ_CMD
      && program_busy_in && !cs_s2_q
      |=> state_q == ST_SKIP && reject_q == (octal && !dr_mode))
      else $error("single-rate read taken while busy");
   AST_REJECT_DR: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_CMD && in_done && in_byte == OCT_DR_READ_CMD
      && program_busy_in && !cs_s2_q
      |=> state_q != ST_ADDR && reject_q == dr_mode)
      else $error("double-rate read taken while busy");
   AST_BOOT_START: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_IDLE && frame_start && boot_armed_q && !cs_s2_q
      |=> state_q == ST_BOOT && addr_q[3:0] == 4'h0)
      else $error("fast boot did not start");
   AST_NORMAL_CMD: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_IDLE && frame_start && !boot_armed_q
      |=> state_q == ST_CMD)
      else $error("command phase not entered");
   AST_SPI_DELAY: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_BOOT && !octal && !cs_s2_q
      |=> (state_q == ST_DATA) == ($past(cnt_q) >= 6'h0d))
      else $error("single-line boot delay not thirteen");
   AST_BOOT_DELAY_END: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_BOOT && cnt_q < boot_delay && !cs_s2_q
      |=> state_q != ST_DATA)
      else $error("boot data before delay elapsed");
   AST_WRAP_SET: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_WRAP && in_done && in_byte == 8'h02 && !cs_s2_q
      |=> wrap_en_q && wrap_code_q == 2'h2)
      else $error("wrap byte not decoded");
   AST_DR_LINEAR: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      req_fire && rd_dr_q && state_q != ST_IDLE
      |=> addr_q == $past(addr_q) + 32'h1)
      else $error("double-rate read wrapped");
   AST_PRE_OFF: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_DUMMY && !cfg_in.preamble_enable
      ##1 state_q == ST_DUMMY |-> oe_q == 8'h00)
      else $error("preamble driven while disabled");
   AST_PRE_SAME: assert property (@(posedge clk_sys_in)
      disable iff (reset_in)
      state_q == ST_DUMMY && cfg_in.pattern_select && oe_q == 8'hff
      |-> io_q == 8'h00 || io_q == 8'hff)
      else $error("lines differ with pattern select set");

   COV_BOOT: cover property (@(posedge clk_sys_in)
      state_q == ST_BOOT ##[1:300] pop);
   COV_SR_READ: cover property (@(posedge clk_sys_in)
      sr_read_q && pop);
   COV_DR_READ: cover property (@(posedge clk_sys_in)
      rd_dr_q && state_q == ST_DATA && pop);
   COV_WRAP_BURST: cover property (@(posedge clk_sys_in)
      wrap_en_q && sr_read_q && req_fire);
endmodule

// ===== pkg/flash_read_pkg.sv
/*
 * shared constants and carriers for the octal flash read sequencer.
 * assumes the link pins are sampled by the system clock and that the
 * flash array answers read requests through a valid/ready port.
 */
package flash_read_pkg;
   // instruction bytes
   localparam logic [7:0] OCT_SR_READ_CMD = 8'hec;
   localparam logic [7:0] OCT_DR_READ_CMD = 8'hee;
   localparam logic [7:0] WRAP_SET_CMD = 8'hc0;
   localparam logic [7:0] SOFT_RESET_CMD = 8'h99;
   // wrap byte decoding
   localparam logic [3:0] WRAP_OFF_NIBBLE = 4'h1;
   localparam logic [3:0] WRAP_SET_NIBBLE = 4'h0;
   localparam logic [1:0] WRAP_CODE_16 = 2'h1;
   localparam logic [1:0] WRAP_CODE_64 = 2'h3;
   localparam int WRAP_SHIFT_BASE = 3;
   // boot configuration fields and reset value
   localparam int BOOT_EN_N_BIT = 0;
   localparam int BOOT_DLY_LSB = 1;
   localparam int BOOT_ADDR_LSB = 4;
   localparam logic [31:0] BOOT_REG_RESET = 32'hffff_ffff;
   // boot delays in link clock cycles
   localparam logic [5:0] BOOT_DLY_00 = 6'h0b;
   localparam logic [5:0] BOOT_DLY_01 = 6'h0f;
   localparam logic [5:0] BOOT_DLY_10 = 6'h11;
   localparam logic [5:0] BOOT_DLY_11 = 6'h15;
   localparam logic [5:0] BOOT_DLY_SPI = 6'h0d;
   // read framing and preamble placement, in link beats
   localparam logic [5:0] ADDR_LAST_BEAT = 6'h03;
   localparam logic [5:0] PREAMBLE_BITS = 6'h10;
   localparam logic [5:0] PRE_SR_BEATS = 6'h04;
   localparam logic [5:0] PRE_DR_BEATS = 6'h08;
   // training patterns, values arbitrary
   localparam logic [15:0] PREAMBLE_A = 16'h349a;
   localparam logic [15:0] PREAMBLE_A_LINE3 = 16'h00ff;
   localparam logic [15:0] PREAMBLE_B = 16'h5555;
   localparam int LINE_THREE = 3;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [7:0] io;
   } link_in_t;

   typedef struct packed {
      logic [7:0] io;
      logic [7:0] oe;
   } link_out_t;

   typedef struct packed {
      logic oct_sr_enable;
      logic oct_dr_enable;
      logic preamble_enable;
      logic pattern_select;
      logic [4:0] dummy_cycles;
   } cfg_t;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_CMD = 8'h02,
      ST_WRAP = 8'h04,
      ST_ADDR = 8'h08,
      ST_DUMMY = 8'h10,
      ST_BOOT = 8'h20,
      ST_DATA = 8'h40,
      ST_SKIP = 8'h80
   } state_t;
endpackage

// ===== verif/host_model.sv
/*
 * host side of the octal link: opens frames, clocks beats, captures io.
 * assumes a 200 ns link clock that stands low outside frames.
 */
`timescale 1ns/1ps
module host_model
   import flash_read_pkg::*;
(
   output link_in_t pins_out,
   input wire link_out_t pins_in
);
   // idle: deselected, clock low
   initial pins_out = '{cs_n: 1'h1, sclk: 1'h0, io: 8'h00};

   // opens a frame with the clock low
   task automatic start();
      pins_out.cs_n = 1'h0;
      #100;
   endtask

   // one rise and fall; released lines toggle so no stale value shows
   task automatic beat(input logic drive, input logic [7:0] d,
                       output logic [7:0] q);
      pins_out.io = drive ? d : ~pins_out.io;
      #100 pins_out.sclk = 1'h1;
      #99 q = pins_in.io ^ ~pins_in.oe; // undriven lines read inverted
      #1 pins_out.sclk = 1'h0;
   endtask

   // one double-rate edge: data mid-way, capture, then toggle the clock
   task automatic half_beat(input logic drive, input logic [7:0] d,
                            output logic [7:0] q);
      #50 pins_out.io = drive ? d : ~pins_out.io;
      #49 q = pins_in.io ^ ~pins_in.oe;
      #1 pins_out.sclk = ~pins_out.sclk;
   endtask

   // closes the frame while the clock is low, then idles
   task automatic stop();
      #100 pins_out.cs_n = 1'h1;
      #400;
   endtask
endmodule

// ===== verif/testbench.sv
/*
 * self-checking bench of the octal flash read sequencer.
 * assumes the host model drives the link and this bench answers the array.
 */
`timescale 1ns/1ps
module testbench;
   import flash_read_pkg::*;
   logic clk_sys_in = 1'h0;
   logic reset_in = 1'h1;
   link_in_t link_pins;
   link_out_t link_out;
   cfg_t cfg = '0;
   logic program_busy = 1'h0;
   logic [31:0] boot_cfg = BOOT_REG_RESET;
   logic req_valid, rsp_ready, reject, wrap_en, boot_pend;
   logic [31:0] req_addr;
   logic rsp_valid = 1'h0;
   logic [7:0] rsp_data = 8'h00;
   logic [3:0] tick = 4'h0;
   logic [7:0] cap [64];
   logic [31:0] addr_log [$];
   int error_cnt = 0;
   int checked = 0;
   int rej_cnt = 0;

   // system clock, 25 ns
   always #12.5 clk_sys_in = ~clk_sys_in;

   octal_flash_read_features i_dut (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .link_pins_in(link_pins),
      .link_pins_out(link_out),
      .cfg_in(cfg),
      .program_busy_in(program_busy),
      .boot_configuration_in(boot_cfg),
      .mem_req_valid_out(req_valid),
      .mem_req_ready_in(tick[0]),
      .mem_addr_out(req_addr),
      .mem_rsp_valid_in(rsp_valid),
      .mem_rsp_data_in(rsp_data),
      .mem_rsp_ready_out(rsp_ready),
      .cmd_reject_out(reject),
      .wrap_enable_out(wrap_en),
      .boot_pending_out(boot_pend)
   );

   host_model i_host (
      .pins_out(link_pins),
      .pins_in(link_out)
   );

   // array stub: stalls every other cycle, one byte per request
   always @(posedge clk_sys_in) begin
      tick <= tick + 4'h1;
      if (req_valid && tick[0]) begin
         addr_log.push_back(req_addr);
         rsp_data <= req_addr[7:0] ^ 8'ha5;
         rsp_valid <= 1'h1;
      end else if (rsp_ready) begin
         rsp_valid <= 1'h0;
      end
      if (reject) rej_cnt++;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk_sys_in);
      #2 reset_in = 1'h1;
      repeat (16) @(posedge clk_sys_in);
      #2 reset_in = 1'h0;
      repeat (6) @(posedge clk_sys_in);
   endtask

   // one link beat: a whole clock in single rate, one edge in double rate
   task automatic step(input logic drive, input logic [7:0] d,
                       output logic [7:0] q);
      if (cfg.oct_dr_enable) begin
         i_host.half_beat(drive, d, q);
      end else begin
         i_host.beat(drive, d, q);
      end
   endtask

   // one frame: hdr command/address beats, then n released, captured beats
   task automatic frame(input logic [7:0] cmd, input logic [31:0] a,
                        input int hdr, input int n);
      logic [7:0] q;
      @(posedge clk_sys_in);
      #2;
      addr_log.delete();
      foreach (cap[i]) cap[i] = 8'hxx;
      i_host.start();
      for (int i = 0; i < hdr; i++)
         step(1'h1, i == 0 ? cmd : 8'(a >> (8 * (4 - i))), q);
      for (int i = 0; i < n; i++) begin
         step(1'h0, 8'h00, q);
         cap[i] = q;
      end
      i_host.stop();
   endtask

   // looks for a whole 16-bit pattern on all lines, line three apart
   function automatic logic has_pre(input logic [15:0] p,
                                    input logic [15:0] p3);
      logic ok;
      for (int k = 0; k <= 24; k++) begin
         ok = 1'h1;
         for (int j = 0; j < 16; j++)
            for (int l = 0; l < 8; l++)
               if (cap[k+j][l] !== (l == LINE_THREE ? p3[15-j] : p[15-j]))
                  ok = 1'h0;
         if (ok) return 1'h1;
      end
      return 1'h0;
   endfunction

   function automatic int find(input logic [7:0] b);
      for (int i = 0; i < 64; i++)
         if (cap[i] === b) return i;
      return -1;
   endfunction

   // main sequence
   initial begin
      logic [7:0] b;
      logic [5:0] dly [4];
      dly = '{6'h0b, 6'h0f, 6'h11, 6'h15};
      do_reset();
      check(boot_pend, 1'h0);
      check(wrap_en, 1'h0);
      // single-rate octal read, preamble a, twenty dummies
      cfg = {1'h1, 1'h0, 1'h1, 1'h0, 5'h14};
      frame(OCT_SR_READ_CMD, 32'h0000_0100, 5, 26);
      check(has_pre(PREAMBLE_A, PREAMBLE_A_LINE3), 1'h1);
      check(addr_log[0], 32'h0000_0100);
      check(cap[find(8'ha5) + 1], 8'ha4);
      cfg.pattern_select = 1'h1;
      frame(OCT_SR_READ_CMD, 32'h0000_0100, 5, 26);
      check(has_pre(PREAMBLE_B, PREAMBLE_B), 1'h1);
      cfg.preamble_enable = 1'h0;
      frame(OCT_SR_READ_CMD, 32'h0000_0100, 5, 26);
      check(has_pre(PREAMBLE_B, PREAMBLE_B), 1'h0);
      cfg = {1'h1, 1'h0, 1'h1, 1'h0, 5'h0c};
      frame(OCT_SR_READ_CMD, 32'h0000_0100, 5, 20);
      check(has_pre(PREAMBLE_A, PREAMBLE_A_LINE3), 1'h0);
      // wrap codes on and off
      for (int c = 1; c < 4; c++) begin
         frame(WRAP_SET_CMD, 32'(c) << 24, 2, 0);
         check(wrap_en, 1'h1);
         frame(WRAP_SET_CMD, (32'(c) | 32'h10) << 24, 2, 0);
         check(wrap_en, 1'h0);
      end
      frame(WRAP_SET_CMD, 32'h0100_0000, 2, 0);
      frame(WRAP_SET_CMD, 32'h0000_0000, 2, 0);
      check(wrap_en, 1'h1);
      cfg = {1'h1, 1'h0, 1'h0, 1'h0, 5'h14};
      frame(OCT_SR_READ_CMD, 32'h0000_020e, 5, 26);
      for (int j = 0; j < 4; j++)
         check(addr_log[j], 32'h200 | ((32'he + 32'(j)) & 32'hf));
      // double-rate read: linear with wrap on, full preamble in twelve
      cfg = {1'h0, 1'h1, 1'h1, 1'h0, 5'h0c};
      frame(OCT_DR_READ_CMD, 32'h0000_020e, 5, 29);
      check(has_pre(PREAMBLE_A, PREAMBLE_A_LINE3), 1'h1);
      for (int j = 0; j < 4; j++)
         check(addr_log[j], 32'h20e + 32'(j));
      check(cap[25], 8'hab);
      program_busy = 1'h1;
      rej_cnt = 0;
      frame(OCT_DR_READ_CMD, 32'h0000_020e, 5, 3);
      check(32'(rej_cnt), 32'h1);
      program_busy = 1'h0;
      cfg = {1'h1, 1'h0, 1'h0, 1'h0, 5'h14};
      frame(SOFT_RESET_CMD, 32'h0, 1, 0);
      check(wrap_en, 1'h0);
      // read refused while a write cycle runs
      program_busy = 1'h1;
      rej_cnt = 0;
      frame(OCT_SR_READ_CMD, 32'h0000_0100, 5, 24);
      check(32'(rej_cnt), 32'h1);
      check(32'(addr_log.size()), 32'h0);
      program_busy = 1'h0;
      // octal fast boot for every delay code
      for (int c = 0; c < 4; c++) begin
         boot_cfg = {28'h0000123, 1'h1, 2'(c), 1'h0};
         do_reset();
         check(boot_pend, 1'h1);
         frame(8'h00, 32'h0, 0, 28);
         check(addr_log[0], 32'h0000_1230);
         check(32'(find(8'h95)), 32'(dly[c]));
         check(boot_pend, 1'h0);
      end
      frame(SOFT_RESET_CMD, 32'h0, 1, 0);
      check(boot_pend, 1'h1);
      // single-line fast boot ignores the delay field
      cfg = '0;
      boot_cfg = {28'h0000123, 1'h1, 2'h0, 1'h0};
      do_reset();
      frame(8'h00, 32'h0, 0, 30);
      for (int i = 0; i < 8; i++)
         b[7-i] = cap[13+i][1];
      check(b, 8'h95);
      finish_test();
   end

   // watchdog against a hung frame
   initial begin
      #1000000;
      error_cnt++;
      finish_test();
   end
endmodule
